/* inc/rmie_pkg.sv */
package rmie_pkg;
    // ****************************************
    // register map (apb byte addresses)
    // ****************************************
    localparam logic [7:0] RMIE_ADDR_RESTART = 8'h00;
    localparam logic [7:0] RMIE_ADDR_SAVED = 8'h04;
    localparam logic [7:0] RMIE_ADDR_STATE = 8'h08;
    localparam logic [7:0] RMIE_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] RMIE_ADDR_ENABLE = 8'h10;
    localparam logic [7:0] RMIE_ADDR_CLEAR = 8'h14;
    localparam logic [7:0] RMIE_ADDR_VECTOR = 8'h18;
    // ****************************************
    // machine state bit positions (bit 0 = msb)
    // ****************************************
    localparam int RMIE_EE = 31 - 16;
    localparam int RMIE_PR = 31 - 17;
    localparam int RMIE_FP = 31 - 18;
    localparam int RMIE_ME = 31 - 19;
    localparam int RMIE_FE = 31 - 20;
    localparam int RMIE_AL = 31 - 24;
    localparam int RMIE_IP = 31 - 25;
    localparam int RMIE_IR = 31 - 26;
    localparam int RMIE_DR = 31 - 27;
    // bits cleared on entry; reserved bits are never touched
    localparam logic [31:0] RMIE_RESET_CLR = 32'h0000_e8b0;
    localparam logic [31:0] RMIE_MCHK_CLR = 32'h0000_f8b0;
    localparam logic [31:0] RMIE_STATE_RST = 32'h0000_1040;
    localparam logic [31:0] RMIE_OFF_RESET = 32'h0000_0100;
    localparam logic [31:0] RMIE_OFF_MCHK = 32'h0000_0200;
    localparam logic [31:0] RMIE_BASE_LOW = 32'h0000_0000;
    localparam logic [31:0] RMIE_BASE_HIGH = 32'hfff0_0000;
    localparam logic [31:0] RMIE_ADDR_MASK = 32'hffff_fffc;
    // status bits
    localparam int RMIE_ST_RESET = 0;
    localparam int RMIE_ST_MCHK = 1;
    localparam int RMIE_ST_STOP = 2;
    localparam int RMIE_NEV = 3;

    typedef struct packed {
        logic addr_parity;
        logic addr_match;
        logic ecc_uncorr;
    } rmie_mem_err_t;

    typedef struct packed {
        logic [31:0] addr;
        logic valid;
    } rmie_fetch_t;

    typedef enum logic [1:0] {
        RMIE_RUN = 2'b00,
        RMIE_STOPPED = 2'b01
    } rmie_state_t;
endpackage

/* logic/rmie_entry.sv */
`timescale 1ns/1ps
module rmie_entry
    import rmie_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sys_reset_req,
    input wire logic [31:0] cur_addr,
    input wire logic [31:0] next_addr,
    input wire logic cur_excepts,
    input wire rmie_mem_err_t icache_reload_err,
    input wire rmie_mem_err_t dcache_reload_err,
    input wire rmie_mem_err_t dcache_store_err,
    input wire logic internal_parity_err,
    input wire logic hang_detect,
    input wire logic hw_err_detect,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output rmie_fetch_t fetch_redirect,
    output logic check_stop,
    output logic irq
);
    // ****************************************
    // registers and combinational decode signals
    // ****************************************
    logic [31:0] saved_restart_address;
    logic [31:0] saved_interrupt_state;
    logic [31:0] machine_state;
    logic [RMIE_NEV-1:0] status;
    logic [RMIE_NEV-1:0] enable;
    rmie_state_t state;
    logic mchk_src;
    logic stop_src;
    logic take_reset;
    logic take_mchk;
    logic go_stop;
    logic wr;
    logic rd;
    logic [31:0] next_state;
    logic [RMIE_NEV-1:0] ev;

    assign mchk_src = (|icache_reload_err) | (|dcache_reload_err) | (|dcache_store_err);
    assign stop_src = internal_parity_err | hang_detect | hw_err_detect;
    assign take_reset = sys_reset_req;
    assign take_mchk = !take_reset && state == RMIE_RUN && mchk_src
        && machine_state[RMIE_ME];
    assign go_stop = !take_reset && state == RMIE_RUN
        && ((mchk_src && !machine_state[RMIE_ME]) || stop_src);
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && !penable && !pwrite;
    assign ev = {go_stop, take_mchk, take_reset};

    // ****************************************
    // machine state update
    // ****************************************
    always_comb
    begin
        next_state = machine_state;
        if (take_reset)
        begin
            next_state = machine_state & ~RMIE_RESET_CLR;
        end
        else if (take_mchk)
        begin
            next_state = machine_state & ~RMIE_MCHK_CLR;
        end
        else if (wr && paddr == RMIE_ADDR_STATE && state == RMIE_RUN)
        begin
            next_state = pwdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            machine_state <= RMIE_STATE_RST;
        end
        else
        begin
            machine_state <= next_state;
        end
    end

    // imprecise entry: later instructions are not fenced here
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            saved_restart_address <= 32'h0000_0000;
            saved_interrupt_state <= 32'h0000_0000;
        end
        else if (take_reset || take_mchk)
        begin
            saved_restart_address <= (cur_excepts ? cur_addr : next_addr)
                & RMIE_ADDR_MASK;
            saved_interrupt_state <= {16'h0000, machine_state[15:0]};
        end
        else if (wr && paddr == RMIE_ADDR_RESTART)
        begin
            saved_restart_address <= pwdata & RMIE_ADDR_MASK;
        end
        else if (wr && paddr == RMIE_ADDR_SAVED)
        begin
            saved_interrupt_state <= pwdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fetch_redirect <= '0;
        end
        else
        begin
            fetch_redirect.valid <= take_reset || take_mchk;
            // held between entries so software can read back the last vector
            if (take_reset || take_mchk)
            begin
                fetch_redirect.addr <= (machine_state[RMIE_IP] ? RMIE_BASE_HIGH : RMIE_BASE_LOW)
                    | (take_reset ? RMIE_OFF_RESET : RMIE_OFF_MCHK);
            end
        end
    end

    // ****************************************
    // check stop
    // ****************************************
    // only a reset request leaves the halt; nothing resumes the old program
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= RMIE_RUN;
        end
        else
        begin
            case (state)
                RMIE_RUN:
                begin
                    if (go_stop)
                    begin
                        state <= RMIE_STOPPED;
                    end
                end
                RMIE_STOPPED:
                begin
                    if (take_reset)
                    begin
                        state <= RMIE_RUN;
                    end
                end
                default:
                begin
                    state <= RMIE_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            check_stop <= 1'b0;
        end
        else
        begin
            check_stop <= take_reset ? 1'b0 : (go_stop || state == RMIE_STOPPED);
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            status <= '0;
            enable <= '0;
        end
        else
        begin
            status <= (status & ~((wr && paddr == RMIE_ADDR_CLEAR) ?
                pwdata[RMIE_NEV-1:0] : '0)) | ev;
            if (wr && paddr == RMIE_ADDR_ENABLE)
            begin
                enable <= pwdata[RMIE_NEV-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(next_status_f() & enable);
        end
    end

    function automatic logic [RMIE_NEV-1:0] next_status_f();
        next_status_f = (status & ~((wr && paddr == RMIE_ADDR_CLEAR) ?
            pwdata[RMIE_NEV-1:0] : '0)) | ev;
    endfunction

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > RMIE_ADDR_VECTOR;
            if (rd)
            begin
                case (paddr)
                    RMIE_ADDR_RESTART: prdata <= saved_restart_address;
                    RMIE_ADDR_SAVED: prdata <= saved_interrupt_state;
                    RMIE_ADDR_STATE: prdata <= machine_state;
                    RMIE_ADDR_STATUS: prdata <= {29'h0, status};
                    RMIE_ADDR_ENABLE: prdata <= {29'h0, enable};
                    RMIE_ADDR_VECTOR: prdata <= fetch_redirect.addr;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_save_low;
        @(posedge ref_clk) disable iff (rst)
        saved_restart_address[1:0] == 2'b00;
    endproperty
    a_save_low: assert property (p_save_low) else $error("restart low bits set");

    property p_reset_vec;
        @(posedge ref_clk) disable iff (rst)
        take_reset |=> fetch_redirect.valid && fetch_redirect.addr[19:0] == 20'h00100;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("bad reset vector");

    property p_mchk_vec;
        @(posedge ref_clk) disable iff (rst)
        take_mchk |=> fetch_redirect.valid && fetch_redirect.addr[19:0] == 20'h00200;
    endproperty
    a_mchk_vec: assert property (p_mchk_vec) else $error("bad mchk vector");

    property p_saved_state;
        @(posedge ref_clk) disable iff (rst)
        (take_reset || take_mchk) |=>
            saved_interrupt_state == {16'h0000, $past(machine_state[15:0])};
    endproperty
    a_saved_state: assert property (p_saved_state) else $error("saved state wrong");

    property p_reset_keep;
        @(posedge ref_clk) disable iff (rst)
        take_reset |=> machine_state[RMIE_ME] == $past(machine_state[RMIE_ME])
            && !machine_state[RMIE_EE] && !machine_state[RMIE_DR];
    endproperty
    a_reset_keep: assert property (p_reset_keep) else $error("reset state wrong");

    property p_mchk_clear;
        @(posedge ref_clk) disable iff (rst)
        take_mchk |=> !machine_state[RMIE_ME]
            && machine_state[RMIE_IP] == $past(machine_state[RMIE_IP]);
    endproperty
    a_mchk_clear: assert property (p_mchk_clear) else $error("mchk state wrong");

    property p_no_mchk_disabled;
        @(posedge ref_clk) disable iff (rst)
        (mchk_src && !machine_state[RMIE_ME] && !sys_reset_req && state == RMIE_RUN)
            |=> !fetch_redirect.valid && check_stop;
    endproperty
    a_no_mchk_disabled: assert property (p_no_mchk_disabled) else $error("mchk while off");

    property p_stop_hold;
        @(posedge ref_clk) disable iff (rst)
        (state == RMIE_STOPPED && !sys_reset_req) |=> check_stop && state == RMIE_STOPPED;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("left check stop");

    property p_prio;
        @(posedge ref_clk) disable iff (rst)
        (sys_reset_req && mchk_src) |=> fetch_redirect.addr[9:8] == 2'b01;
    endproperty
    a_prio: assert property (p_prio) else $error("reset lost priority");
endmodule

/* tb/rmie_mem_model.sv */
`timescale 1ns/1ps
// ****************************************
// memory subsystem error reporter
// ****************************************
module rmie_mem_model
    import rmie_pkg::*;
(
    input wire logic fire,
    input wire logic [1:0] src,
    input wire rmie_mem_err_t kind,
    output rmie_mem_err_t icache_err,
    output rmie_mem_err_t dreload_err,
    output rmie_mem_err_t dstore_err
);
    // errors show only in the cycle the bench fires them, otherwise the lines read clean
    assign icache_err = (fire && src == 2'd0) ? kind : '0;
    assign dreload_err = (fire && src == 2'd1) ? kind : '0;
    // storebacks never carry an ecc report, so that bit is dropped here
    assign dstore_err = (fire && src == 2'd2) ? (kind & 3'b110) : '0;
endmodule

/* tb/rmie_entry_tb.sv */
`timescale 1ns/1ps
module rmie_entry_tb
    import rmie_pkg::*;
;
    typedef struct packed {
        logic rq;
        logic [1:0] src;
        logic [2:0] kind;
        logic exc;
        logic [31:0] ms;
    } rmie_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sys_reset_req = 1'b0;
    logic cur_excepts = 1'b0;
    logic fire = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic internal_parity_err = 1'b0;
    logic hang_detect = 1'b0;
    logic hw_err_detect = 1'b0;
    logic [1:0] src = 2'd3;
    rmie_mem_err_t kind = '0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] cur_addr = 32'h0;
    logic [31:0] next_addr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic check_stop;
    logic irq;
    rmie_fetch_t fetch_redirect;
    rmie_mem_err_t ie;
    rmie_mem_err_t dre;
    rmie_mem_err_t dse;
    int err_total = 0;
    int compares = 0;
    logic [31:0] q;
    logic [31:0] vaddr;
    logic serr;
    logic vld;

    always #5 ref_clk = ~ref_clk;

    rmie_mem_model mem (.fire(fire), .src(src), .kind(kind), .icache_err(ie),
        .dreload_err(dre), .dstore_err(dse));
    rmie_entry dut (.ref_clk(ref_clk), .rst(rst), .sys_reset_req(sys_reset_req),
        .cur_addr(cur_addr), .next_addr(next_addr), .cur_excepts(cur_excepts),
        .icache_reload_err(ie), .dcache_reload_err(dre), .dcache_store_err(dse),
        .internal_parity_err(internal_parity_err), .hang_detect(hang_detect),
        .hw_err_detect(hw_err_detect), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_redirect(fetch_redirect), .check_stop(check_stop),
        .irq(irq));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one cycle of event inputs, then look at the registered answer
    task automatic ev(input logic rq, input logic [1:0] s, input logic [2:0] k,
        input logic [2:0] stp);
        @(posedge ref_clk);
        sys_reset_req <= rq;
        fire <= (s != 2'd3);
        src <= s;
        kind <= k;
        {internal_parity_err, hang_detect, hw_err_detect} <= stp;
        @(posedge ref_clk);
        sys_reset_req <= 1'b0;
        fire <= 1'b0;
        {internal_parity_err, hang_detect, hw_err_detect} <= 3'b000;
        #1;
        vld = fetch_redirect.valid;
        vaddr = fetch_redirect.addr;
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        rmie_row_t rows [6];
        logic [31:0] ms;
        logic [31:0] ca;
        rows = '{'{1'b1, 2'd3, 3'b000, 1'b1, 32'h0000_ff70},
                 '{1'b1, 2'd3, 3'b000, 1'b0, 32'h0000_0000},
                 '{1'b0, 2'd0, 3'b100, 1'b1, 32'h0000_1000},
                 '{1'b0, 2'd1, 3'b001, 1'b0, 32'h0000_ff70},
                 '{1'b0, 2'd2, 3'b010, 1'b1, 32'h0000_9040},
                 '{1'b1, 2'd0, 3'b100, 1'b0, 32'h0000_1040}};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, RMIE_ADDR_STATE, 32'h0);
        chk("state_reset", q, RMIE_STATE_RST);
        for (int i = 0; i < 6; i++)
        begin
            ms = rows[i].ms;
            apb(1'b1, RMIE_ADDR_STATE, ms);
            // low address bits set on purpose: saved address must come back aligned
            cur_addr <= 32'h0001_0003 + i;
            next_addr <= 32'h0002_0006 + i;
            cur_excepts <= rows[i].exc;
            ev(rows[i].rq, rows[i].src, rows[i].kind, 3'b000);
            ca = (rows[i].exc ? 32'h0001_0003 + i : 32'h0002_0006 + i) & RMIE_ADDR_MASK;
            chk("valid", vld, 32'h1);
            chk("vector", vaddr, (ms[RMIE_IP] ? RMIE_BASE_HIGH : RMIE_BASE_LOW)
                | (rows[i].rq ? RMIE_OFF_RESET : RMIE_OFF_MCHK));
            apb(1'b0, RMIE_ADDR_RESTART, 32'h0);
            chk("restart", q, ca);
            apb(1'b0, RMIE_ADDR_SAVED, 32'h0);
            chk("saved", q, ms & 32'h0000_ffff);
            apb(1'b0, RMIE_ADDR_STATE, 32'h0);
            chk("state", q, ms & ~(rows[i].rq ? RMIE_RESET_CLR : RMIE_MCHK_CLR));
            $display("row %0d done", i);
        end
        apb(1'b0, RMIE_ADDR_VECTOR, 32'h0);
        chk("last_vector", q, RMIE_BASE_HIGH | RMIE_OFF_RESET);
        apb(1'b0, RMIE_ADDR_STATUS, 32'h0);
        chk("status_ev", q, 32'h3);
        chk("no_slverr", serr, 32'h0);
        apb(1'b1, RMIE_ADDR_STATE, 32'h0000_0040);
        ev(1'b0, 2'd1, 3'b001, 3'b000);
        chk("no_vector", vld, 32'h0);
        chk("stop", check_stop, 32'h1);
        apb(1'b0, RMIE_ADDR_STATUS, 32'h0);
        chk("stop_flag", q[RMIE_ST_STOP], 32'h1);
        ev(1'b1, 2'd3, 3'b000, 3'b000);
        chk("stop_exit", check_stop, 32'h0);
        for (int j = 0; j < 3; j++)
        begin
            ev(1'b0, 2'd3, 3'b000, 3'b100 >> j);
            chk("hw_stop", check_stop, 32'h1);
            ev(1'b1, 2'd3, 3'b000, 3'b000);
        end
        $display("check stop done");
        apb(1'b1, RMIE_ADDR_CLEAR, 32'h7);
        apb(1'b1, RMIE_ADDR_ENABLE, 32'h1);
        ev(1'b1, 2'd3, 3'b000, 3'b000);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq_on", irq, 32'h1);
        apb(1'b1, RMIE_ADDR_ENABLE, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq_masked", irq, 32'h0);
        apb(1'b1, RMIE_ADDR_CLEAR, 32'h1);
        apb(1'b0, RMIE_ADDR_STATUS, 32'h0);
        chk("status_clear", q[RMIE_ST_RESET], 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk("slverr", serr, 32'h1);
        chk("unmapped", q, 32'h0);
        $display("interrupt and bus done");
        ev(1'b0, 2'd3, 3'b000, 3'b001);
        chk("stop_pre_rst", check_stop, 32'h1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk("rst_stop", check_stop, 32'h0);
        chk("rst_vld", fetch_redirect.valid, 32'h0);
        apb(1'b0, RMIE_ADDR_STATE, 32'h0);
        chk("rst_state", q, RMIE_STATE_RST);
        $display("mid-run reset done");
        finish_test();
    end

    // whole run is about 150 cycles; this leaves ample margin
    initial
    begin
        #50000;
        err_total++;
        finish_test();
    end
endmodule
